// File: core/lrx_symbol_sync.sv
// lane receive bit recovery, symbol alignment and word sync
`timescale 1ns/1ps
module lrx_symbol_sync
	import lrx_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic rxSerial,
	input wire logic pllMode,
	input wire logic pllBitStrobe,
	input wire logic pllBitData,
	output logic [9:0] symData,
	output logic symComma,
	output logic symValid,
	input wire logic symReady,
	output logic syncLost,
	output logic overflow
);
	// ************************************************************
	// input synchronisers
	// ************************************************************
	logic [1:0] serMeta, strbMeta, pllDatMeta, modeMeta;
	logic serSync, serPrev, strbSync, strbPrev, pllDatSync, modeSync;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			serMeta <= 2'h0;
			strbMeta <= 2'h0;
			pllDatMeta <= 2'h0;
			modeMeta <= 2'h0;
			serPrev <= 1'b0;
			strbPrev <= 1'b0;
		end else begin
			serMeta <= {serMeta[0], rxSerial};
			strbMeta <= {strbMeta[0], pllBitStrobe};
			pllDatMeta <= {pllDatMeta[0], pllBitData};
			modeMeta <= {modeMeta[0], pllMode};
			serPrev <= serSync;
			strbPrev <= strbSync;
		end
	end
	assign serSync = serMeta[1];
	assign strbSync = strbMeta[1];
	assign pllDatSync = pllDatMeta[1];
	assign modeSync = modeMeta[1];

	// ************************************************************
	// decoding helpers
	// ************************************************************
	function automatic logic [3:0] onesOf(input logic [9:0] w);
		logic [3:0] n;
		n = 4'h0;
		for (int i = 0; i < SYM_W; i++) begin
			n = n + {3'h0, w[i]};
		end
		return n;
	endfunction

	function automatic logic isComma7(input logic [6:0] w);
		return (w == COMMA7_NEG) || (w == COMMA7_POS);
	endfunction

	// ************************************************************
	// bit recovery
	// ************************************************************
	logic [2:0] phase, next_phase;
	logic bitTake, bitVal;

	always_comb begin
		// every edge restarts the phase, so a slow drift never accumulates
		next_phase = (serSync != serPrev) ? 3'h0 : phase + 3'h1;
		if (modeSync) begin
			bitTake = strbSync && !strbPrev;
			bitVal = pllDatSync;
		end else begin
			// an edge landing on the sample point opens a new bit, so nothing is taken twice
			bitTake = (phase == SAMPLE_PHASE) && (serSync == serPrev);
			bitVal = serSync;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			phase <= 3'h0;
		end else begin
			phase <= next_phase;
		end
	end

	// ************************************************************
	// deserialiser and comma aligner
	// ************************************************************
	logic [8:0] shift, next_shift;
	logic [3:0] bitCnt, next_bitCnt;
	logic rd, next_rd;
	logic [9:0] word;
	logic realign, symEnd, commaRx, symBad;
	logic [3:0] ones;

	always_comb begin
		word = {shift, bitVal};
		ones = onesOf(word);
		// a comma seen off the current boundary means the boundary is wrong, K28.7 included
		realign = bitTake && isComma7(word[9:3]) && (bitCnt != BIT_LAST);
		symEnd = bitTake && ((bitCnt == BIT_LAST) || realign);
		commaRx = (word == K287_NEG) || (word == K287_POS)
			|| (word == INIT_COMMA_NEG) || (word == INIT_COMMA_POS);
		symBad = 1'b0;
		next_rd = rd;
		if (ones == ONES_HIGH) begin
			symBad = rd;
			next_rd = 1'b1;
		end else if (ones == ONES_LOW) begin
			symBad = !rd;
			next_rd = 1'b0;
		end else if (ones != ONES_NEUTRAL) begin
			symBad = 1'b1;
		end
		if (!symEnd) begin
			next_rd = rd;
		end
		next_shift = bitTake ? word[8:0] : shift;
		next_bitCnt = symEnd ? 4'h0 : (bitTake ? bitCnt + 4'h1 : bitCnt);
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			shift <= 9'h000;
			bitCnt <= 4'h0;
			rd <= 1'b0;
		end else begin
			shift <= next_shift;
			bitCnt <= next_bitCnt;
			rd <= next_rd;
		end
	end

	// ************************************************************
	// word sync state machine
	// ************************************************************
	lrx_sync_e state, next_state;
	logic [2:0] errCnt, next_errCnt;

	always_comb begin
		next_state = state;
		next_errCnt = errCnt;
		case (state)
			SYNC_LOST_STATE: begin
				next_errCnt = 3'h0;
				if (symEnd && commaRx) begin
					next_state = SYNC_CHECK_STATE;
				end
			end
			SYNC_CHECK_STATE: begin
				if (realign) begin
					next_state = SYNC_LOST_STATE;
				end else if (symEnd && symBad) begin
					if (errCnt == ERR_LIMIT) begin
						next_state = SYNC_LOST_STATE;
					end else begin
						next_errCnt = errCnt + 3'h1;
					end
				end
			end
			default: begin
				next_state = SYNC_LOST_STATE;
			end
		endcase
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state <= SYNC_LOST_STATE;
			errCnt <= 3'h0;
		end else begin
			state <= next_state;
			errCnt <= next_errCnt;
		end
	end

	// ************************************************************
	// hand-off to the decoder
	// ************************************************************
	lrx_fifo_if #(.W(FIFO_WIDTH)) pushPort();
	lrx_fifo_if #(.W(FIFO_WIDTH)) popPort();
	logic next_overflow;

	// a serial line cannot be held off, so a full fifo drops and flags
	assign pushPort.valid = symEnd;
	assign pushPort.data = {commaRx, word};
	assign next_overflow = symEnd && !pushPort.ready;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			overflow <= 1'b0;
		end else begin
			overflow <= next_overflow;
		end
	end

	lrx_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) symFifo (
		.clk(clk),
		.reset(reset),
		.inPort(pushPort.sink),
		.outPort(popPort.source)
	);

	assign popPort.ready = symReady;
	assign symValid = popPort.valid;
	assign symData = popPort.data[9:0];
	assign symComma = popPort.data[SYM_W];
	assign syncLost = (state == SYNC_LOST_STATE);
endmodule // lrx_symbol_sync

// File: core/lrx_pkg.sv
// constants shared by the lane receive symbol and word sync block
package lrx_pkg;
	// ************************************************************
	// timing and oversampling
	// ************************************************************
	localparam int CLK_MHZ = 20;
	localparam int BIT_TOL_PCT = 1;
	localparam int SAMPLE_WINDOW_PCT = 25;
	localparam int OVS_RATIO = 8;
	localparam logic [2:0] OVS_LAST = 3'h7;
	// sample three clocks after the resync point, which sits one clock behind the edge
	localparam logic [2:0] SAMPLE_PHASE = 3'h3;

	// ************************************************************
	// symbol codes, transmission order a first in bit 9
	// ************************************************************
	localparam int SYM_W = 10;
	localparam logic [3:0] BIT_LAST = 4'h9;
	localparam logic [9:0] K287_NEG = 10'h0f8;
	localparam logic [9:0] K287_POS = 10'h307;
	localparam logic [9:0] INIT_COMMA_NEG = 10'h0f9;
	localparam logic [9:0] INIT_COMMA_POS = 10'h306;
	localparam logic [6:0] COMMA7_NEG = 7'h1f;
	localparam logic [6:0] COMMA7_POS = 7'h60;
	localparam logic [3:0] ONES_NEUTRAL = 4'h5;
	localparam logic [3:0] ONES_HIGH = 4'h6;
	localparam logic [3:0] ONES_LOW = 4'h4;

	// ************************************************************
	// word sync
	// ************************************************************
	localparam logic [2:0] ERR_LIMIT = 3'h4;
	localparam int FIFO_DEPTH = 16;
	localparam int FIFO_WIDTH = SYM_W + 1;

	typedef enum logic [1:0] {
		SYNC_LOST_STATE = 2'h1,
		SYNC_CHECK_STATE = 2'h2
	} lrx_sync_e;
endpackage

// File: core/lrx_fifo_if.sv
// valid/ready stream carrier between the sync logic and its fifo
`timescale 1ns/1ps
interface lrx_fifo_if #(parameter int W = 11);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport source (output valid, output data, input ready);
	modport sink (input valid, input data, output ready);
endinterface

// File: core/lrx_fifo.sv
// parameterised fifo with registered read data
`timescale 1ns/1ps
module lrx_fifo #(
	parameter int WIDTH = 11,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic reset,
	lrx_fifo_if.sink inPort,
	lrx_fifo_if.source outPort
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtr, next_wrPtr, rdPtr, next_rdPtr;
	logic [AW:0] count, next_count;
	logic outValid, next_outValid;
	logic [WIDTH-1:0] outData, next_outData;
	logic push, load;

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		push = inPort.valid && (count < (AW+1)'(DEPTH));
		load = (count != '0) && (!outValid || outPort.ready);
		next_wrPtr = push ? wrPtr + 1'b1 : wrPtr;
		next_rdPtr = load ? rdPtr + 1'b1 : rdPtr;
		next_count = count + (AW+1)'(push) - (AW+1)'(load);
		next_outData = load ? mem[rdPtr] : outData;
		next_outValid = load ? 1'b1 : (outPort.ready ? 1'b0 : outValid);
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
			outValid <= 1'b0;
			outData <= '0;
		end else begin
			wrPtr <= next_wrPtr;
			rdPtr <= next_rdPtr;
			count <= next_count;
			outValid <= next_outValid;
			outData <= next_outData;
		end
	end

	// storage has no reset, it is only read behind a nonzero count
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wrPtr] <= inPort.data;
		end
	end

	assign inPort.ready = count < (AW+1)'(DEPTH);
	assign outPort.valid = outValid;
	assign outPort.data = outData;
endmodule // lrx_fifo

// File: verification/lrx_symbol_sync_asserts.sv
// port checker for the lane receive sync block
`timescale 1ns/1ps
module lrx_symbol_sync_asserts
	import lrx_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic [9:0] symData,
	input wire logic symComma,
	input wire logic symValid,
	input wire logic symReady,
	input wire logic syncLost,
	input wire logic overflow
);
	// ****
	// properties
	// ****
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	logic isComma;
	assign isComma = symData inside {K287_NEG, K287_POS, INIT_COMMA_NEG, INIT_COMMA_POS};
	a_valid_holds: assert property (symValid && !symReady |=> symValid) else $error("valid lost");
	a_data_holds: assert property (symValid && !symReady |=> $stable(symData)) else $error("data moved");
	a_comma_flag: assert property (symValid |-> symComma == isComma) else $error("comma flag");
	a_ovf_pulse: assert property (overflow |=> !overflow) else $error("long overflow");
	a_ovf_full: assert property (overflow |-> symValid) else $error("overflow when empty");
	// state moves need a newly taken bit, so neither state can flicker
	a_check_hold: assert property ($fell(syncLost) |=> !syncLost [*8]) else $error("check short");
	a_lost_hold: assert property ($rose(syncLost) |=> syncLost [*8]) else $error("lost short");
	a_reset_vals: assert property ($past(reset) |-> syncLost && !symValid && !overflow)
		else $error("reset values");
	c_overflow: cover property (overflow);
	c_lock: cover property ($fell(syncLost));
	c_comma_out: cover property (symValid && symReady && symComma);
endmodule // lrx_symbol_sync_asserts

bind lrx_symbol_sync lrx_symbol_sync_asserts chk (.clk(clk), .reset(reset), .symData(symData),
	.symComma(symComma), .symValid(symValid), .symReady(symReady), .syncLost(syncLost),
	.overflow(overflow));

// File: verification/lrx_tx_model.sv
// far end lane transmitter model
`timescale 1ns/1ps
module lrx_tx_model #(
	parameter realtime BIT_NS = 404.0
) (
	output logic serialOut,
	output logic strobe,
	output logic bitData
);
	initial begin
		serialOut = 1'b0;
		strobe = 1'b0;
		bitData = 1'b0;
	end
	// a goes first; strobe rises mid bit so data is settled around it
	task automatic send(input logic [9:0] sym, input int n);
		for (int i = 9; i > 9 - n; i--) begin
			serialOut = sym[i];
			bitData = sym[i];
			#(BIT_NS / 2) strobe = 1'b1;
			#(BIT_NS / 2) strobe = 1'b0;
		end
	endtask
endmodule // lrx_tx_model

// File: verification/lrx_symbol_sync_tb_top.sv
// self-checking bench for the lane receive sync block
`timescale 1ns/1ps
module lrx_symbol_sync_tb_top
	import lrx_pkg::*;
;
	// ****
	// bench
	// ****
	localparam logic [9:0] DAT = 10'h2aa;
	localparam logic [9:0] BAD = 10'h3ff;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic pllMode = 1'b0;
	logic symReady = 1'b1;
	wire rxSerial, pllBitStrobe, pllBitData;
	logic [9:0] symData;
	logic symComma, symValid, syncLost, overflow;
	logic [10:0] rx[$];
	int errors = 0;
	int checks_done = 0;
	int drops = 0;
	initial forever #25 clk = ~clk;
	lrx_tx_model tx (.serialOut(rxSerial), .strobe(pllBitStrobe), .bitData(pllBitData));
	lrx_symbol_sync dut (.clk(clk), .reset(reset), .rxSerial(rxSerial), .pllMode(pllMode),
		.pllBitStrobe(pllBitStrobe), .pllBitData(pllBitData), .symData(symData),
		.symComma(symComma), .symValid(symValid), .symReady(symReady), .syncLost(syncLost),
		.overflow(overflow));
	always @(posedge clk) begin
		if (symValid === 1'b1 && symReady === 1'b1) rx.push_back({symComma, symData});
		if (overflow === 1'b1) drops++;
	end
	task automatic report_and_stop();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk_sym(input string what, input logic [10:0] exp, input logic [10:0] got);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk_bit(input string what, input logic exp, input logic got);
		chk_sym(what, {10'h0, exp}, {10'h0, got});
	endtask
	function automatic logic [10:0] tail(input int k);
		return rx[rx.size() - k];
	endfunction
	// bounded wait until the output side has drained
	task automatic settle();
		for (int n = 0; n < 60; n++) begin
			repeat (4) @(posedge clk);
			if (symValid === 1'b0) return;
		end
		errors++;
		report_and_stop();
	endtask
	task automatic do_reset();
		reset <= 1'b1;
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		repeat (2) @(posedge clk);
		chk_bit("syncLost", 1'b1, syncLost);
		chk_bit("symValid", 1'b0, symValid);
	endtask
	task automatic t_lock_k287();
		pllMode <= 1'b0;
		tx.send(DAT, 10);
		tx.send(DAT, 10);
		tx.send(K287_NEG, 10);
		tx.send(DAT, 10);
		settle();
		chk_sym("comma", {1'b1, K287_NEG}, tail(2));
		chk_sym("data", {1'b0, DAT}, tail(1));
		chk_bit("syncLost", 1'b0, syncLost);
		$display("test lock_k287 done");
	endtask
	task automatic t_init_pll();
		pllMode <= 1'b1;
		tx.send(DAT, 10);
		tx.send(INIT_COMMA_NEG, 10);
		tx.send(DAT, 10);
		tx.send(K287_POS, 10);
		tx.send(DAT, 10);
		tx.send(INIT_COMMA_POS, 10);
		tx.send(DAT, 10);
		settle();
		chk_sym("init comma", {1'b1, INIT_COMMA_NEG}, tail(6));
		chk_sym("comma pos", {1'b1, K287_POS}, tail(4));
		chk_sym("init comma pos", {1'b1, INIT_COMMA_POS}, tail(2));
		chk_bit("syncLost", 1'b0, syncLost);
		$display("test init_pll done");
	endtask
	task automatic t_error_count();
		for (int i = 0; i < 4; i++) begin
			tx.send(BAD, 10);
		end
		settle();
		chk_bit("syncLost", 1'b0, syncLost);
		tx.send(BAD, 10);
		settle();
		chk_bit("syncLost", 1'b1, syncLost);
		$display("test error_count done");
	endtask
	task automatic t_realign();
		pllMode <= 1'b0;
		tx.send(K287_NEG, 10);
		tx.send(DAT, 10);
		settle();
		chk_bit("syncLost", 1'b0, syncLost);
		tx.send(DAT, 5);
		tx.send(K287_NEG, 10);
		tx.send(DAT, 10);
		settle();
		chk_bit("syncLost", 1'b1, syncLost);
		chk_sym("data", {1'b0, DAT}, tail(1));
		$display("test realign done");
	endtask
	// the lane cannot be stalled, so a stuck decoder must cost symbols
	task automatic t_overflow();
		int n0;
		int d0;
		n0 = rx.size();
		d0 = drops;
		symReady <= 1'b0;
		for (int i = 0; i < 18; i++) begin
			tx.send(DAT, 10);
		end
		repeat (2) @(posedge clk);
		chk_bit("symValid", 1'b1, symValid);
		chk_bit("dropped", 1'b1, drops > d0);
		symReady <= 1'b1;
		settle();
		chk_sym("total", 11'h012, 11'(rx.size() - n0 + drops - d0));
		$display("test overflow done");
	endtask
	initial begin
		do_reset();
		t_lock_k287();
		do_reset();
		t_init_pll();
		t_error_count();
		t_realign();
		t_overflow();
		report_and_stop();
	end
endmodule // lrx_symbol_sync_tb_top
